// file: hw/thwm_consts.svh
// constants for the thermal warning monitor: offsets, fields, resets, timing
// Summary of operation
// - supervision always runs in active or sleep
// - two-bit threshold select, 90..120 C, reset 10
// - hysteresis bit 3: 8 or 16 C, reset 1
// - warning held until below threshold minus hysteresis
// - live warning status at bit 15, read-only
// - interrupt flag set on both warning edges
// - flag bit 1, cleared by writing one
// - flag feeds primary interrupt unless masked
// - mask bit: 0 passes, 1 blocks, reset 1
// - shutdown detect forces system reset to off
`ifndef THWM_CONSTS_SVH
`define THWM_CONSTS_SVH

// register offsets
`define THWM_ADDR_CFG        16'h4002
`define THWM_ADDR_STATUS     16'h400D
`define THWM_ADDR_IRQ_STS    16'h4011
`define THWM_ADDR_IRQ_MASK   16'h4019

// field positions
`define THWM_CFG_THR_LSB     0
`define THWM_CFG_THR_MSB     1
`define THWM_CFG_HYST_BIT    3
`define THWM_STATUS_WARN_BIT 15
`define THWM_IRQ_WARN_BIT    1

// reset values
`define THWM_CFG_THR_RST     2'h2
`define THWM_CFG_HYST_RST    1'h1
`define THWM_IRQ_MASK_RST    1'h1

// system reset request pulse, least width
`define THWM_CLK_PERIOD_NS   10
`define THWM_RST_PULSE_NS    1000
`define THWM_RST_PULSE_CYC   ((`THWM_RST_PULSE_NS + `THWM_CLK_PERIOD_NS - 1) / `THWM_CLK_PERIOD_NS)

`endif

// file: hw/thwm_hyst.sv
// warning latch with hysteresis release
`timescale 1ns/1ns
module thwm_hyst (
   // clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_arst_n,
   // control
   input  wire logic i_enable,
   // synchronised comparator levels
   input  wire logic i_above_thr,
   input  wire logic i_above_release,
   // warning level
   output logic      o_warn
);

   thwm_pkg::thwm_hyst_s state_reg;
   thwm_pkg::thwm_hyst_s state_next;

   // raise at threshold, drop only below threshold minus margin
   always_comb begin
      state_next = state_reg;
      if (i_enable) begin
         if (i_above_thr) begin
            state_next.warn = 1'b1;
         end else if (!i_above_release) begin
            state_next.warn = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_warn = state_reg.warn;

endmodule

// file: hw/thwm_pkg.sv
// types shared by the thermal warning monitor modules
package thwm_pkg;

   // shutdown reset request sequencer, one-hot
   typedef enum logic [1:0] {
      THWM_RST_IDLE = 2'b01,
      THWM_RST_HOLD = 2'b10
   } thwm_rst_state_e;

   // hysteresis latch state
   typedef struct packed {
      logic warn;
   } thwm_hyst_s;

   // top-level state
   typedef struct packed {
      logic [1:0]      thr_sel;
      logic            hyst_sel;
      logic            irq_mask;
      logic            irq_flag;
      logic            warn_prev;
      logic [15:0]     rdata;
      logic            irq_out;
      thwm_rst_state_e rst_state;
      logic [7:0]      rst_cnt;
      logic            rst_req;
   } thwm_state_s;

endpackage

// file: hw/thwm_sync.sv
// two-stage synchroniser for asynchronous comparator levels
`timescale 1ns/1ns
module thwm_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_arst_n,
   // asynchronous in, synchronous out
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } thwm_sync_s;

   thwm_sync_s state_reg;
   thwm_sync_s state_next;

   // first stage feeds only the second
   always_comb begin
      state_next        = state_reg;
      state_next.stage1 = i_async;
      state_next.stage2 = state_reg.stage1;
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_sync = state_reg.stage2;

endmodule

// file: hw/thwm_top.sv
// thermal warning monitor: registers, warning interrupt, shutdown reset
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "thwm_consts.svh"
module thwm_top (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_arst_n,
   // register port
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // power state
   input  wire logic        i_pwr_active,
   input  wire logic        i_pwr_sleep,
   // analogue comparators, asynchronous
   input  wire logic        i_cmp_above_thr,
   input  wire logic        i_cmp_above_release,
   input  wire logic        i_cmp_shutdown,
   // analogue trim selects
   output logic      [1:0]  o_warn_threshold_sel,
   output logic             o_warn_hysteresis_sel,
   // system outputs
   output logic             o_thermal_irq,
   output logic             o_sys_reset_req
);

   // register slots
   typedef enum logic [3:0] {
      THWM_SEL_NONE = 4'b0000,
      THWM_SEL_CFG  = 4'b0001,
      THWM_SEL_STS  = 4'b0010,
      THWM_SEL_IRQ  = 4'b0100,
      THWM_SEL_MASK = 4'b1000
   } thwm_sel_e;

   // address decode shared by reads and writes
   function automatic thwm_sel_e thwm_decode(input logic [15:0] addr);
      thwm_sel_e sel;
      sel = THWM_SEL_NONE;
      if (addr == `THWM_ADDR_CFG) begin
         sel = THWM_SEL_CFG;
      end else if (addr == `THWM_ADDR_STATUS) begin
         sel = THWM_SEL_STS;
      end else if (addr == `THWM_ADDR_IRQ_STS) begin
         sel = THWM_SEL_IRQ;
      end else if (addr == `THWM_ADDR_IRQ_MASK) begin
         sel = THWM_SEL_MASK;
      end
      return sel;
   endfunction

   localparam logic [7:0] RST_LAST = 8'(`THWM_RST_PULSE_CYC - 1);

   thwm_pkg::thwm_state_s state_reg;
   thwm_pkg::thwm_state_s state_next;

   logic [2:0] cmp_sync;
   logic       supervise;
   logic       warn;
   logic       shutdown;
   thwm_sel_e  wsel;
   thwm_sel_e  rsel;
   logic       warn_edge;
   logic       irq_clr;

   // comparator synchronisation
   thwm_sync #(
      .WIDTH (3)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_async   ({i_cmp_shutdown, i_cmp_above_release, i_cmp_above_thr}),
      .o_sync    (cmp_sync)
   );

   // supervision in active and sleep, no enable bit
   assign supervise = i_pwr_active | i_pwr_sleep;
   assign shutdown  = cmp_sync[2] & supervise;

   // warning latch
   thwm_hyst u_hyst (
      .i_ref_clk       (i_ref_clk),
      .i_arst_n        (i_arst_n),
      .i_enable        (supervise),
      .i_above_thr     (cmp_sync[0]),
      .i_above_release (cmp_sync[1]),
      .o_warn          (warn)
   );

   // decode and event terms
   assign wsel      = i_wr ? thwm_decode(i_addr) : THWM_SEL_NONE;
   assign rsel      = i_rd ? thwm_decode(i_addr) : THWM_SEL_NONE;
   assign warn_edge = warn ^ state_reg.warn_prev;
   assign irq_clr   = (wsel == THWM_SEL_IRQ) & i_wdata[`THWM_IRQ_WARN_BIT];

   // next state
   always_comb begin
      state_next           = state_reg;
      state_next.warn_prev = warn;

      // configuration and mask writes
      if (wsel == THWM_SEL_CFG) begin
         state_next.thr_sel  = i_wdata[`THWM_CFG_THR_MSB:`THWM_CFG_THR_LSB];
         state_next.hyst_sel = i_wdata[`THWM_CFG_HYST_BIT];
      end
      if (wsel == THWM_SEL_MASK) begin
         state_next.irq_mask = i_wdata[`THWM_IRQ_WARN_BIT];
      end

      // sticky flag, a new edge beats the clear
      state_next.irq_flag = warn_edge | (state_reg.irq_flag & ~irq_clr);

      // primary interrupt, mask high blocks
      state_next.irq_out = state_next.irq_flag & ~state_next.irq_mask;

      // read data for one cycle only
      state_next.rdata = 16'h0000;
      if (rsel == THWM_SEL_CFG) begin
         state_next.rdata[`THWM_CFG_THR_MSB:`THWM_CFG_THR_LSB] = state_reg.thr_sel;
         state_next.rdata[`THWM_CFG_HYST_BIT]                  = state_reg.hyst_sel;
      end else if (rsel == THWM_SEL_STS) begin
         state_next.rdata[`THWM_STATUS_WARN_BIT] = warn;
      end else if (rsel == THWM_SEL_IRQ) begin
         state_next.rdata[`THWM_IRQ_WARN_BIT] = state_reg.irq_flag;
      end else if (rsel == THWM_SEL_MASK) begin
         state_next.rdata[`THWM_IRQ_WARN_BIT] = state_reg.irq_mask;
      end

      // shutdown reset request, held a least width
      case (state_reg.rst_state)
         thwm_pkg::THWM_RST_IDLE: begin
            state_next.rst_cnt = 8'h00;
            state_next.rst_req = 1'b0;
            if (shutdown) begin
               state_next.rst_state = thwm_pkg::THWM_RST_HOLD;
               state_next.rst_req   = 1'b1;
            end
         end
         thwm_pkg::THWM_RST_HOLD: begin
            state_next.rst_req = 1'b1;
            if (state_reg.rst_cnt >= RST_LAST) begin
               if (!shutdown) begin
                  state_next.rst_state = thwm_pkg::THWM_RST_IDLE;
                  state_next.rst_req   = 1'b0;
               end
            end else begin
               state_next.rst_cnt = state_reg.rst_cnt + 8'h01;
            end
         end
         default: begin
            state_next.rst_state = thwm_pkg::THWM_RST_IDLE;
            state_next.rst_cnt   = 8'h00;
            state_next.rst_req   = 1'b0;
         end
      endcase
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg.thr_sel   <= `THWM_CFG_THR_RST;
         state_reg.hyst_sel  <= `THWM_CFG_HYST_RST;
         state_reg.irq_mask  <= `THWM_IRQ_MASK_RST;
         state_reg.irq_flag  <= 1'b0;
         state_reg.warn_prev <= 1'b0;
         state_reg.rdata     <= 16'h0000;
         state_reg.irq_out   <= 1'b0;
         state_reg.rst_state <= thwm_pkg::THWM_RST_IDLE;
         state_reg.rst_cnt   <= 8'h00;
         state_reg.rst_req   <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops
   assign o_rdata               = state_reg.rdata;
   assign o_warn_threshold_sel  = state_reg.thr_sel;
   assign o_warn_hysteresis_sel = state_reg.hyst_sel;
   assign o_thermal_irq         = state_reg.irq_out;
   assign o_sys_reset_req       = state_reg.rst_req;

endmodule

// file: verif/tb.sv
// self-checking bench for the thermal warning monitor
`timescale 1ns/1ns
module tb;
   logic        i_ref_clk = 1'h0, i_arst_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
   logic        i_pwr_active = 1'h1, i_pwr_sleep = 1'h0;
   logic [15:0] i_addr = 16'h0000, i_wdata = 16'h0000, o_rdata;
   logic [7:0]  temp = 8'h32;
   logic [3:0]  n;
   logic [1:0]  o_warn_threshold_sel;
   logic        o_warn_hysteresis_sel, o_thermal_irq, o_sys_reset_req;
   logic        i_cmp_above_thr, i_cmp_above_release, i_cmp_shutdown;
   int          bad_count = 0, num_checks = 0, w;
   // clock and instances
   always #5 i_ref_clk = ~i_ref_clk;
   thwm_top thwm_top_i (.*);
   thwm_sensor_model thwm_sensor_model_i (.i_temp(temp), .i_thr_sel(o_warn_threshold_sel),
      .i_hyst_sel(o_warn_hysteresis_sel), .o_above_thr(i_cmp_above_thr),
      .o_above_release(i_cmp_above_release), .o_shutdown(i_cmp_shutdown));
   // compare, bus cycles, temperature steps, verdict
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
         bad_count++;
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'h1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'h0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge i_ref_clk);
      i_rd <= 1'h1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'h0;
      #1;
      chk($sformatf("reg %h", a), e, o_rdata);
   endtask
   task automatic heat(input logic [7:0] t);
      @(posedge i_ref_clk);
      temp <= t;
      repeat (6) @(posedge i_ref_clk);
   endtask
   task automatic test_done;
      if (bad_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge i_ref_clk);
      i_arst_n <= 1'h1;
      rd(16'h4002, 16'h000A);
      rd(16'h4019, 16'h0002);
      rd(16'h400D, 16'h0000);
      rd(16'h4011, 16'h0000);
      for (n = 4'h0; n < 4'h8; n++) begin
         wr(16'h4002, {12'hFFF, n[2], 1'h1, n[1:0]});
         rd(16'h4002, {12'h000, n[2], 1'h0, n[1:0]});
         chk("sel pins", {13'h0000, n[2:0]}, {13'h0000, o_warn_hysteresis_sel, o_warn_threshold_sel});
      end
      rd(16'h4003, 16'h0000);
      wr(16'h400D, 16'hFFFF);
      rd(16'h400D, 16'h0000);
      wr(16'h4002, 16'h0000);
      wr(16'h4019, 16'h0000);
      heat(8'h5F);
      rd(16'h400D, 16'h8000);
      rd(16'h4011, 16'h0002);
      chk("irq pin", 16'h0001, {15'h0000, o_thermal_irq});
      wr(16'h4011, 16'h0002);
      rd(16'h4011, 16'h0000);
      heat(8'h55);
      rd(16'h400D, 16'h8000);
      rd(16'h4011, 16'h0000);
      heat(8'h50);
      rd(16'h400D, 16'h0000);
      rd(16'h4011, 16'h0002);
      wr(16'h4019, 16'h0002);
      rd(16'h4019, 16'h0002);
      chk("irq masked", 16'h0000, {15'h0000, o_thermal_irq});
      wr(16'h4011, 16'h0002);
      i_pwr_active <= 1'h0;
      heat(8'h96);
      rd(16'h400D, 16'h0000);
      chk("req off", 16'h0000, {15'h0000, o_sys_reset_req});
      @(posedge i_ref_clk);
      i_pwr_sleep <= 1'h1;
      for (w = 0; w < 10 && o_sys_reset_req !== 1'h1; w++) begin
         @(posedge i_ref_clk);
         #1;
      end
      chk("req sleep", 16'h0001, {15'h0000, o_sys_reset_req});
      rd(16'h400D, 16'h8000);
      // shutdown level gone early, so the request holds only its least width
      @(posedge i_ref_clk);
      temp <= 8'h32;
      // w counts the cycles since the request rose, three already spent
      for (w = 3; w < 400 && o_sys_reset_req !== 1'h0; w++) begin
         @(posedge i_ref_clk);
         #1;
      end
      chk("req width", 16'h0064, w[15:0]);
      test_done;
   end
endmodule

// file: verif/thwm_checker.sv
// port-level assertions for the thermal warning monitor
`timescale 1ns/1ns
module thwm_checker (
   // clock and reset
   input wire logic        i_ref_clk,
   input wire logic        i_arst_n,
   // register port
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   // comparator and outputs
   input wire logic        i_cmp_shutdown,
   input wire logic [1:0]  o_warn_threshold_sel,
   input wire logic        o_warn_hysteresis_sel,
   input wire logic        o_thermal_irq,
   input wire logic        o_sys_reset_req
);
   logic [15:0] wd_q;
   logic        mask_q;
   logic [7:0]  hi_cnt;
   // previous-cycle write data bus, mask shadow, request width counter
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wd_q <= 16'h0000;
         mask_q <= 1'h1;
         hi_cnt <= 8'h00;
      end else begin
         wd_q <= i_wdata;
         mask_q <= (i_wr && i_addr == 16'h4019) ? i_wdata[1] : mask_q;
         hi_cnt <= !o_sys_reset_req ? 8'h00 : (hi_cnt == 8'hFF) ? hi_cnt : hi_cnt + 8'h01;
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   a_cfg_write: assert property (i_wr && i_addr == 16'h4002 |=>
      o_warn_threshold_sel == wd_q[1:0] && o_warn_hysteresis_sel == wd_q[3]) else $error("config write lost");
   a_sel_hold: assert property (!(i_wr && i_addr == 16'h4002) |=>
      $stable(o_warn_threshold_sel) && $stable(o_warn_hysteresis_sel)) else $error("selects moved");
   a_cfg_read: assert property (i_rd && i_addr == 16'h4002 |=>
      o_rdata == {12'h000, o_warn_hysteresis_sel, 1'h0, o_warn_threshold_sel}) else $error("config read");
   a_mask_read: assert property (i_rd && i_addr == 16'h4019 |=>
      o_rdata == {14'h0000, mask_q, 1'h0}) else $error("mask read");
   a_status_bits: assert property (i_rd && i_addr == 16'h400D |=>
      o_rdata[14:0] == 15'h0000) else $error("status spare bits");
   a_irq_masked: assert property (mask_q && $past(mask_q) |-> !o_thermal_irq)
      else $error("masked irq seen");
   a_req_cause: assert property ($rose(o_sys_reset_req) |-> $past(i_cmp_shutdown, 3))
      else $error("reset request without cause");
   a_req_width: assert property ($fell(o_sys_reset_req) |-> hi_cnt >= 8'h64)
      else $error("reset request too short");
endmodule
bind thwm_top thwm_checker thwm_checker_i (.*);

// file: verif/thwm_sensor_model.sv
// behavioural model of the on-die temperature comparators
`timescale 1ns/1ns
module thwm_sensor_model #(
   parameter logic [7:0] SHUTDOWN_C = 8'h8C
) (
   // die temperature in degrees and trim selects
   input  wire logic [7:0] i_temp,
   input  wire logic [1:0] i_thr_sel,
   input  wire logic       i_hyst_sel,
   // comparator levels
   output logic            o_above_thr,
   output logic            o_above_release,
   output logic            o_shutdown
);
   logic [7:0] thr_c;
   logic [7:0] rel_c;
   // threshold and release levels, then comparisons
   assign thr_c = 8'h5A + {6'h00, i_thr_sel} * 8'h0A;
   assign rel_c = thr_c - (i_hyst_sel ? 8'h10 : 8'h08);
   assign o_above_thr = i_temp >= thr_c;
   assign o_above_release = i_temp >= rel_c;
   assign o_shutdown = i_temp >= SHUTDOWN_C;
endmodule
